// ==== design/temp_monitor_pkg.sv ====
// Constants and types shared by the temperature monitor serial port and alarm logic.
// Operation
// RULE1 - Sample data on clock rising edges; change own data only on falling edges.
// RULE2 - Data line is open-drain: only pull low or release, never drive high.
// RULE3 - The master holds the serial clock high whenever the bus is idle.
// RULE4 - Assert the open-drain alarm output when temperature moves beyond programmed limits.
// RULE5 - Alarm runs in interrupt or comparator mode, chosen by one mode bit.
// RULE6 - Alarm is active-low after reset; the polarity bit makes it active-high.
// RULE7 - The three low slave address bits come from the three address straps.
// RULE8 - Straps are weakly pulled low so a floating strap reads as zero. No pull-down here: the strap pins are captured as driven.
// RULE9 - Shared alarm lines should all be configured active-low by the host.
// RULE10 - Bytes move MSB first; receiver answers ACK or NACK on ninth clock.
// RULE11 - Acknowledge a matching address; on mismatch, do not acknowledge and go idle.
// RULE12 - Filter and synchronise clock and data; detect start and stop while clock high.
package temp_monitor_pkg;

    localparam logic [3:0] DEVICE_TYPE_ID = 4'h9;
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         SPIKE_NS       = 20;
    localparam int         FILTER_CYCLES  = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] FILTER_LAST    = 2'(FILTER_CYCLES - 1);
    localparam logic [1:0] STRAP_SETTLE   = 2'h3;
    localparam logic       LINE_IDLE      = 1'b1;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    typedef enum logic [2:0] {
        IDLE,
        ADDR,
        ADDR_ACK,
        WRITE,
        WRITE_ACK,
        READ,
        READ_ACK
    } serial_state_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [1:0] cnt;
        logic out;
    } filter_state_type;

    typedef struct packed {
        serial_state_type state;
        logic [2:0]       cnt;
        logic             done;
        logic [7:0]       shift;
        logic             sda_oe;
        logic             sda_drv;
        logic             ack;
        logic [7:0]       wr_byte;
        logic             wr_valid;
        logic             rd_next;
        logic             alarm_int;
        logic             over_prev;
        logic             alert_oe;
        logic             alert_drv;
        logic [2:0]       strap_s1;
        logic [2:0]       strap_s2;
        logic [1:0]       settle;
        logic             captured;
        logic [2:0]       addr_lsb;
        logic             scl_p;
        logic             sda_p;
    } serial_state_all_type;

endpackage

// ==== design/line_filter.sv ====
// Two-flop synchroniser followed by a spike filter for one serial bus line.
`timescale 1ns/1ps
module line_filter
(
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic line_in,
    output logic      line_out
);

    temp_monitor_pkg::filter_state_type r_reg;
    temp_monitor_pkg::filter_state_type r_next;

    // The filtered level only follows once the synchronised input has held for the whole spike window.
    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = line_in;
        r_next.s2 = r_reg.s1;
        if (r_reg.s2 == r_reg.out)
        begin
            r_next.cnt = 2'h0;
        end
        else if (r_reg.cnt == temp_monitor_pkg::FILTER_LAST)
        begin
            r_next.out = r_reg.s2; // RULE12
            r_next.cnt = 2'h0;
        end
        else
        begin
            r_next.cnt = r_reg.cnt + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r_reg <= '{s1: temp_monitor_pkg::LINE_IDLE, s2: temp_monitor_pkg::LINE_IDLE, cnt: 2'h0,
                       out: temp_monitor_pkg::LINE_IDLE};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign line_out = r_reg.out;

endmodule

// ==== design/temp_monitor_serial_pins.sv ====
// Two-wire serial slave pin logic and open-drain alarm output of the temperature monitor.
`timescale 1ns/1ps
module temp_monitor_serial_pins
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic [2:0] address_strap_inputs_in,
    input  wire logic       alarm_mode_select_in,
    input  wire logic       alarm_polarity_select_in,
    input  wire logic       over_limit_in,
    input  wire logic [7:0] rd_byte_in,
    output logic            rd_next_out,
    output logic [7:0]      wr_byte_out,
    output logic            wr_valid_out,
    output logic            alert_out,
    output logic            alert_oe_out
);

    temp_monitor_pkg::serial_state_all_type r_reg;
    temp_monitor_pkg::serial_state_all_type r_next;

    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_w;
    logic stop_w;
    logic match_w;
    logic alarm_active;

    line_filter scl_filter
    (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .line_in    (scl_in),
        .line_out   (scl_f)
    );

    line_filter sda_filter
    (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .line_in    (sda_in),
        .line_out   (sda_f)
    );

    assign scl_rise = scl_f && !r_reg.scl_p;
    assign scl_fall = !scl_f && r_reg.scl_p;
    assign start_w  = scl_f && r_reg.scl_p && r_reg.sda_p && !sda_f; // RULE12
    assign stop_w   = scl_f && r_reg.scl_p && !r_reg.sda_p && sda_f; // RULE12
    assign match_w  = r_reg.shift[7:1] == {temp_monitor_pkg::DEVICE_TYPE_ID, r_reg.addr_lsb}; // RULE7
    assign alarm_active = alarm_mode_select_in ? r_reg.alarm_int : over_limit_in; // RULE5

    always_comb
    begin
        r_next = r_reg;
        r_next.wr_valid = 1'b0;
        r_next.rd_next = 1'b0;
        r_next.scl_p = scl_f;
        r_next.sda_p = sda_f;
        r_next.strap_s1 = address_strap_inputs_in;
        r_next.strap_s2 = r_reg.strap_s1;
        // Straps are caught once, after the synchroniser has filled with real pin levels.
        if (r_reg.settle != temp_monitor_pkg::STRAP_SETTLE)
        begin
            r_next.settle = r_reg.settle + 2'h1;
        end
        else if (!r_reg.captured)
        begin
            r_next.addr_lsb = r_reg.strap_s2; // RULE7 RULE8
            r_next.captured = 1'b1;
        end
        if (start_w)
        begin
            r_next.state = temp_monitor_pkg::ADDR;
            r_next.cnt = 3'h0;
            r_next.done = 1'b0;
            r_next.sda_oe = 1'b0;
        end
        else if (stop_w)
        begin
            r_next.state = temp_monitor_pkg::IDLE;
            r_next.sda_oe = 1'b0;
        end
        else
        begin
            unique case (r_reg.state)
                temp_monitor_pkg::IDLE:
                begin
                    r_next.sda_oe = 1'b0;
                end
                temp_monitor_pkg::ADDR, temp_monitor_pkg::WRITE:
                begin
                    if (scl_rise)
                    begin
                        r_next.shift = {r_reg.shift[6:0], sda_f}; // RULE1 RULE10
                        r_next.cnt = r_reg.cnt + 3'h1;
                        r_next.done = r_reg.cnt == temp_monitor_pkg::BIT_LAST;
                    end
                    else if (scl_fall && r_reg.done)
                    begin
                        r_next.done = 1'b0;
                        if (r_reg.state == temp_monitor_pkg::WRITE)
                        begin
                            r_next.wr_byte = r_reg.shift;
                            r_next.wr_valid = 1'b1;
                            r_next.sda_oe = 1'b1; // RULE10
                            r_next.state = temp_monitor_pkg::WRITE_ACK;
                        end
                        else if (match_w && r_reg.captured)
                        begin
                            r_next.ack = r_reg.shift[0];
                            r_next.sda_oe = 1'b1; // RULE11
                            r_next.state = temp_monitor_pkg::ADDR_ACK;
                        end
                        else
                        begin
                            r_next.state = temp_monitor_pkg::IDLE; // RULE11
                        end
                    end
                end
                temp_monitor_pkg::ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (r_reg.ack)
                        begin
                            r_next.shift = rd_byte_in;
                            r_next.rd_next = 1'b1;
                            r_next.sda_oe = !rd_byte_in[7]; // RULE1 RULE2
                            r_next.state = temp_monitor_pkg::READ;
                        end
                        else
                        begin
                            r_next.sda_oe = 1'b0;
                            r_next.state = temp_monitor_pkg::WRITE;
                        end
                    end
                end
                temp_monitor_pkg::WRITE_ACK:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe = 1'b0;
                        r_next.state = temp_monitor_pkg::WRITE;
                    end
                end
                temp_monitor_pkg::READ:
                begin
                    if (scl_rise)
                    begin
                        r_next.cnt = r_reg.cnt + 3'h1;
                        r_next.done = r_reg.cnt == temp_monitor_pkg::BIT_LAST;
                    end
                    else if (scl_fall)
                    begin
                        if (r_reg.done)
                        begin
                            r_next.done = 1'b0;
                            r_next.sda_oe = 1'b0;
                            r_next.state = temp_monitor_pkg::READ_ACK;
                        end
                        else
                        begin
                            r_next.shift = {r_reg.shift[6:0], 1'b0};
                            r_next.sda_oe = !r_reg.shift[6]; // RULE1 RULE2 RULE10
                        end
                    end
                end
                temp_monitor_pkg::READ_ACK:
                begin
                    if (scl_rise)
                    begin
                        r_next.ack = !sda_f; // RULE10
                    end
                    else if (scl_fall)
                    begin
                        if (r_reg.ack)
                        begin
                            r_next.shift = rd_byte_in;
                            r_next.rd_next = 1'b1;
                            r_next.sda_oe = !rd_byte_in[7];
                            r_next.state = temp_monitor_pkg::READ;
                        end
                        else
                        begin
                            r_next.state = temp_monitor_pkg::IDLE;
                        end
                    end
                end
            endcase
        end
        // Interrupt mode latches any crossing until the device is next addressed; a new crossing wins.
        r_next.over_prev = over_limit_in;
        if (r_next.state == temp_monitor_pkg::ADDR_ACK && r_reg.state != temp_monitor_pkg::ADDR_ACK)
        begin
            r_next.alarm_int = 1'b0;
        end
        if (alarm_mode_select_in && (over_limit_in != r_reg.over_prev))
        begin
            r_next.alarm_int = 1'b1; // RULE4 RULE5
        end
        if (!alarm_mode_select_in)
        begin
            r_next.alarm_int = 1'b0;
        end
        r_next.alert_oe = alarm_polarity_select_in ? !alarm_active : alarm_active; // RULE4 RULE6 RULE9
        r_next.sda_drv = 1'b0; // RULE2
        r_next.alert_drv = 1'b0;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r_reg <= '{state: temp_monitor_pkg::IDLE, strap_s1: 3'h0, strap_s2: 3'h0, addr_lsb: 3'h0,
                       cnt: 3'h0, shift: 8'h00, wr_byte: 8'h00, settle: 2'h0,
                       scl_p: temp_monitor_pkg::LINE_IDLE, sda_p: temp_monitor_pkg::LINE_IDLE, default: 1'b0};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign sda_out      = r_reg.sda_drv;
    assign sda_oe_out   = r_reg.sda_oe;
    assign rd_next_out  = r_reg.rd_next;
    assign wr_byte_out  = r_reg.wr_byte;
    assign wr_valid_out = r_reg.wr_valid;
    assign alert_out    = r_reg.alert_drv;
    assign alert_oe_out = r_reg.alert_oe;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence addr_byte_done;
        r_reg.state == temp_monitor_pkg::ADDR && scl_fall && r_reg.done && !start_w && !stop_w;
    endsequence

    chk_sda_edge_only: assert property ($changed(sda_oe_out) |-> $past(scl_fall || start_w || stop_w)) // RULE1
        else $error("data line changed away from a falling clock edge");
    chk_sda_never_high: assert property (sda_out == 1'b0) // RULE2
        else $error("data line driven high");
    chk_alarm_comp: assert property ((!alarm_mode_select_in && over_limit_in && !alarm_polarity_select_in) [*2]
        |-> alert_oe_out) // RULE4
        else $error("comparator alarm not asserted while over limit");
    chk_alarm_int_hold: assert property (alarm_mode_select_in && r_reg.alarm_int
        && r_next.state != temp_monitor_pkg::ADDR_ACK |=> r_reg.alarm_int || !alarm_mode_select_in) // RULE5
        else $error("interrupt alarm dropped without being addressed");
    chk_alarm_pol_high: assert property ((!alarm_mode_select_in && !over_limit_in && alarm_polarity_select_in) [*2]
        |-> alert_oe_out) // RULE6
        else $error("inactive active-high alarm not pulled low");
    chk_addr_ack_match: assert property ($rose(r_reg.state == temp_monitor_pkg::ADDR_ACK)
        |-> $past(match_w) && sda_oe_out) // RULE7
        else $error("address acknowledged without match");
    chk_strap_stable: assert property (r_reg.captured && $past(r_reg.captured) |-> $stable(r_reg.addr_lsb)) // RULE8
        else $error("captured address changed");
    chk_write_ack: assert property (wr_valid_out |-> sda_oe_out && r_reg.state == temp_monitor_pkg::WRITE_ACK) // RULE10
        else $error("write byte not acknowledged");
    chk_addr_nack: assert property (addr_byte_done ##0 !match_w |=> r_reg.state == temp_monitor_pkg::IDLE
        && !sda_oe_out) // RULE11
        else $error("mismatched address not released");
    chk_start_detect: assert property (start_w |=> r_reg.state == temp_monitor_pkg::ADDR && !sda_oe_out) // RULE12
        else $error("start condition missed");

endmodule

// ==== tb/host_master_model.sv ====
// Behavioural bus master that drives the serial clock and pulls the data line for the pin logic.
`timescale 1ns/1ps
module host_master_model
(
    input  wire logic sys_clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    // The clock rests high and the data line is released between frames.
    initial
    begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    // Data moves one cycle after the clock falls.
    // The clock then stays low for six cycles in all, high for two, keeping the 80 ns period.
    // The pin logic answers about five cycles after a fall, so its data settles before the next rise.
    // A shorter low phase would let that answer land while the clock is high and look like a start or stop.
    task automatic bit_cyc(input logic b, output logic s);
        wait_cyc(1);
        sda_oe_out <= ~b;
        wait_cyc(5);
        scl_out <= 1'b1;
        wait_cyc(2);
        s = sda_in;
        scl_out <= 1'b0;
    endtask

    task automatic start_cond();
        wait_cyc(1);
        sda_oe_out <= 1'b0;
        wait_cyc(3);
        scl_out <= 1'b1;
        wait_cyc(4);
        sda_oe_out <= 1'b1;
        wait_cyc(4);
        scl_out <= 1'b0;
    endtask

    // After a stop the clock is left high while the bus is idle.
    task automatic stop_cond();
        wait_cyc(1);
        sda_oe_out <= 1'b1;
        wait_cyc(3);
        scl_out <= 1'b1;
        wait_cyc(4);
        sda_oe_out <= 1'b0;
        wait_cyc(8);
    endtask

    // One byte, most significant bit first, then the answer bit on the ninth clock.
    task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(tx[i], rx[i]);
        end
        bit_cyc(ack_tx, ack_rx);
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the serial pin logic and the alarm output.
`timescale 1ns/1ps
module tb;
    logic       sys_clk_in;
    logic       rst_in;
    logic [2:0] strap;
    logic       mode;
    logic       alarm_polarity_select;
    logic       over;
    logic [7:0] rd_byte;
    logic       scl;
    logic       host_oe;
    logic       sda_out_w;
    logic       sda_oe_w;
    logic       rd_next;
    logic [7:0] wr_byte;
    logic       wr_valid;
    logic       alert;
    logic       alert_oe;
    wire        sda_line;
    int         fails;
    int         n_tests;
    int         cycles;
    int         wr_cnt;
    int         rd_cnt;

    // Pull-up on the data line; each party can only pull it low.
    assign sda_line = (sda_oe_w ? sda_out_w : 1'b1) & ~host_oe;

    temp_monitor_serial_pins temp_monitor_serial_pins_i
    (
        .sys_clk_in               (sys_clk_in),
        .rst_in                   (rst_in),
        .scl_in                   (scl),
        .sda_in                   (sda_line),
        .sda_out                  (sda_out_w),
        .sda_oe_out               (sda_oe_w),
        .address_strap_inputs_in  (strap),
        .alarm_mode_select_in     (mode),
        .alarm_polarity_select_in (alarm_polarity_select),
        .over_limit_in            (over),
        .rd_byte_in               (rd_byte),
        .rd_next_out              (rd_next),
        .wr_byte_out              (wr_byte),
        .wr_valid_out             (wr_valid),
        .alert_out                (alert),
        .alert_oe_out             (alert_oe)
    );

    host_master_model host_master_model_i
    (
        .sys_clk_in (sys_clk_in),
        .sda_in     (sda_line),
        .scl_out    (scl),
        .sda_oe_out (host_oe)
    );

    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // Counts pulses and offers the next read byte once the last one was taken.
    always @(posedge sys_clk_in)
    begin
        cycles = cycles + 1;
        if (wr_valid === 1'b1)
            wr_cnt = wr_cnt + 1;
        if (rd_next === 1'b1)
        begin
            rd_cnt = rd_cnt + 1;
            rd_byte <= ~rd_byte;
        end
        if (cycles == 30000)
        begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset();
        rst_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
    endtask

    function automatic logic [7:0] addr(input logic [2:0] s, input logic rw);
        return {temp_monitor_pkg::DEVICE_TYPE_ID, s, rw};
    endfunction

    // Every strap value: own address acknowledged, a neighbour address refused.
    task automatic test_address();
        logic [7:0] rx;
        logic       ack;
        for (int s = 0; s < 8; s++)
        begin
            strap <= 3'(s);
            do_reset();
            host_master_model_i.start_cond();
            host_master_model_i.xfer(addr(3'(s), 1'b0), 1'b1, rx, ack);
            check("own addr ack", 8'(ack), 8'h00);
            host_master_model_i.stop_cond();
            host_master_model_i.start_cond();
            host_master_model_i.xfer(addr(3'(s) ^ 3'h1, 1'b0), 1'b1, rx, ack);
            check("other addr ack", 8'(ack), 8'h01);
            host_master_model_i.xfer(8'h00, 1'b1, rx, ack);
            check("byte after refusal", 8'(ack), 8'h01);
            host_master_model_i.stop_cond();
        end
        $display("test address done");
    endtask

    task automatic test_write();
        logic [7:0] rx;
        logic       ack;
        int         w0;
        w0 = wr_cnt;
        host_master_model_i.start_cond();
        host_master_model_i.xfer(addr(strap, 1'b0), 1'b1, rx, ack);
        check("write addr ack", 8'(ack), 8'h00);
        host_master_model_i.xfer(8'hA6, 1'b1, rx, ack);
        check("data ack", 8'(ack), 8'h00);
        check("first byte", wr_byte, 8'hA6);
        host_master_model_i.xfer(8'h81, 1'b1, rx, ack);
        check("second byte", wr_byte, 8'h81);
        host_master_model_i.stop_cond();
        check("write pulses", 8'(wr_cnt - w0), 8'h02);
        check("line released", 8'(sda_oe_w), 8'h00);
        check("never drives high", 8'(sda_out_w), 8'h00);
        $display("test write done");
    endtask

    task automatic test_read();
        logic [7:0] rx;
        logic [7:0] exp;
        logic       ack;
        int         r0;
        r0 = rd_cnt;
        exp = rd_byte;
        host_master_model_i.start_cond();
        host_master_model_i.xfer(addr(strap, 1'b1), 1'b1, rx, ack);
        check("read addr ack", 8'(ack), 8'h00);
        host_master_model_i.xfer(8'hFF, 1'b0, rx, ack);
        check("read byte 0", rx, exp);
        host_master_model_i.xfer(8'hFF, 1'b1, rx, ack);
        check("read byte 1", rx, ~exp);
        host_master_model_i.stop_cond();
        check("read loads", 8'(rd_cnt - r0), 8'h02);
        check("released after nack", 8'(sda_oe_w), 8'h00);
        $display("test read done");
    endtask

    task automatic set_alarm(input logic m, input logic p, input logic o, input logic exp);
        mode <= m;
        alarm_polarity_select  <= p;
        over <= o;
        repeat (3) @(posedge sys_clk_in);
        check("alarm pull", 8'(alert_oe), 8'(exp));
    endtask

    task automatic test_alarm();
        logic [7:0] rx;
        logic       ack;
        set_alarm(1'b0, 1'b0, 1'b0, 1'b0);
        set_alarm(1'b0, 1'b0, 1'b1, 1'b1);
        set_alarm(1'b0, 1'b1, 1'b1, 1'b0);
        set_alarm(1'b0, 1'b1, 1'b0, 1'b1);
        set_alarm(1'b1, 1'b0, 1'b0, 1'b0);
        set_alarm(1'b1, 1'b0, 1'b1, 1'b1);
        set_alarm(1'b1, 1'b0, 1'b0, 1'b1);
        host_master_model_i.start_cond();
        host_master_model_i.xfer(addr(strap, 1'b0), 1'b1, rx, ack);
        check("latch cleared", 8'(alert_oe), 8'h00);
        host_master_model_i.stop_cond();
        set_alarm(1'b1, 1'b0, 1'b1, 1'b1);
        set_alarm(1'b0, 1'b0, 1'b0, 1'b0);
        check("alarm value", 8'(alert), 8'h00);
        $display("test alarm done");
    endtask

    initial
    begin
        rst_in  = 1'b1;
        strap   = 3'h0;
        mode    = 1'b0;
        alarm_polarity_select     = 1'b0;
        over    = 1'b0;
        rd_byte = 8'h5C;
        fails   = 0;
        n_tests = 0;
        cycles  = 0;
        wr_cnt  = 0;
        rd_cnt  = 0;
        do_reset();
        test_address();
        test_write();
        test_read();
        test_alarm();
        print_verdict();
    end
endmodule
